//--- logic/ouv_supervisor.sv
// output under-voltage supervisor: settings, detection and restart policy
`timescale 1ns/1ps
module ouv_supervisor
	import ouv_pkg::*;
#(
	parameter int unsigned STEP_CYCLES = OUV_STEP_CYCLES
) (
	input  wire logic        ref_clk,      // internal clock, 10 MHz
	input  wire logic        resetn,       // power-on reset, async
	input  wire logic        link_clk,     // management link clock
	input  wire ouv_req_t    pm_req,       // decoded command request
	input  wire logic        pm_req_valid, // request offered
	output logic             pm_req_ready, // request may be taken
	output logic             pm_rsp_valid, // answer pulse
	output logic [15:0]      pm_rsp_data,  // read data
	output logic             pm_rsp_err,   // unmapped command code
	input  wire logic [15:0] vout_code,    // measured output voltage
	input  wire logic        ctrl_on_pin,  // on/off control pin
	input  wire logic        other_fault,  // another supervisor shut down
	input  wire logic        fault_clear,  // fault cleared pulse
	output logic             out_enable,   // converter output enable
	output logic             uv_warn,      // under-voltage warning
	output logic             uv_fault,     // under-voltage fault
	output logic             retry_busy    // restart sequence running
);
	localparam logic [OUV_STEP_CNT_W-1:0] STEP_LAST =
		OUV_STEP_CNT_W'(STEP_CYCLES - 1);

	// ========================================
	// link side: take a request, wait for the answer
	ouv_req_t    lreq_reg, lreq_next;     // request held stable
	logic        lbusy_reg, lbusy_next;   // request outstanding
	logic        lreq_tgl_reg, lreq_tgl_next;
	logic [1:0]  lack_sync_reg;           // ack toggle synchroniser
	logic        lack_seen_reg, lack_seen_next;
	logic        lrsp_v_reg, lrsp_v_next;
	logic [15:0] lrsp_d_reg, lrsp_d_next;
	logic        lrsp_e_reg, lrsp_e_next;
	logic        rack_tgl_reg, rack_tgl_next; // ref side ack toggle
	logic [15:0] rrsp_d_reg, rrsp_d_next;     // ref side answer data
	logic        rrsp_e_reg, rrsp_e_next;
	logic        lack_evt;
	// one request in flight; the next waits for the ack
	assign pm_req_ready = !lbusy_reg;
	assign lack_evt     = lack_sync_reg[1] != lack_seen_reg;
	// link next state
	always_comb begin
		lreq_next      = lreq_reg;
		lbusy_next     = lbusy_reg;
		lreq_tgl_next  = lreq_tgl_reg;
		lack_seen_next = lack_sync_reg[1];
		lrsp_v_next    = 1'b0;
		lrsp_d_next    = lrsp_d_reg;
		lrsp_e_next    = lrsp_e_reg;
		if (pm_req_valid && !lbusy_reg) begin
			// words cross by handshake: held until acked
			lreq_next     = pm_req;
			lbusy_next    = 1'b1;
			lreq_tgl_next = !lreq_tgl_reg;
		end
		if (lack_evt) begin
			// ref answer regs are stable while the ack travels
			lbusy_next  = 1'b0;
			lrsp_v_next = 1'b1;
			lrsp_d_next = rrsp_d_reg;
			lrsp_e_next = rrsp_e_reg;
		end
	end
	// link registers
	always_ff @(posedge link_clk or negedge resetn) begin
		if (!resetn) begin
			lreq_reg      <= '0;
			lbusy_reg     <= 1'b0;
			lreq_tgl_reg  <= 1'b0;
			lack_sync_reg <= 2'h0;
			lack_seen_reg <= 1'b0;
			lrsp_v_reg    <= 1'b0;
			lrsp_d_reg    <= 16'h0000;
			lrsp_e_reg    <= 1'b0;
		end else begin
			lreq_reg      <= lreq_next;
			lbusy_reg     <= lbusy_next;
			lreq_tgl_reg  <= lreq_tgl_next;
			lack_sync_reg <= {lack_sync_reg[0], rack_tgl_reg};
			lack_seen_reg <= lack_seen_next;
			lrsp_v_reg    <= lrsp_v_next;
			lrsp_d_reg    <= lrsp_d_next;
			lrsp_e_reg    <= lrsp_e_next;
		end
	end
	assign pm_rsp_valid = lrsp_v_reg;
	assign pm_rsp_data  = lrsp_d_reg;
	assign pm_rsp_err   = lrsp_e_reg;

	// ========================================
	// ref side: settings
	logic [1:0]  rreq_sync_reg;           // request toggle synchroniser
	logic        rreq_seen_reg, rreq_seen_next;
	logic [15:0] warn_reg, warn_next;     // warning threshold
	logic [15:0] fault_reg, fault_next;   // fault threshold
	ouv_action_t act_reg, act_next;       // fault action
	logic [1:0]  on_sync_reg;             // control pin synchroniser
	logic        rreq_evt;
	logic        on_now;
	assign rreq_evt = rreq_sync_reg[1] != rreq_seen_reg;
	assign on_now   = on_sync_reg[1];
	// settings next state and command decode
	always_comb begin
		rreq_seen_next = rreq_sync_reg[1];
		warn_next      = warn_reg;
		fault_next     = fault_reg;
		act_next       = act_reg;
		rack_tgl_next  = rack_tgl_reg;
		rrsp_d_next    = rrsp_d_reg;
		rrsp_e_next    = rrsp_e_reg;
		if (rreq_evt) begin
			rack_tgl_next = !rack_tgl_reg;
			rrsp_e_next   = 1'b0;
			case (lreq_reg.code)
				OUV_CMD_WARN: begin
					rrsp_d_next = warn_reg;
					if (lreq_reg.write)
						warn_next = lreq_reg.data;
				end
				OUV_CMD_FAULT: begin
					rrsp_d_next = fault_reg;
					if (lreq_reg.write)
						fault_next = lreq_reg.data;
				end
				OUV_CMD_ACT: begin
					// byte wide: upper byte reads as zero
					rrsp_d_next = {8'h00, act_reg};
					if (lreq_reg.write)
						act_next = lreq_reg.data[7:0];
				end
				default: begin
					// unknown code: no store, flagged
					rrsp_d_next = OUV_RD_NONE;
					rrsp_e_next = 1'b1;
				end
			endcase
		end
	end
	// settings registers
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rreq_sync_reg <= 2'h0;
			rreq_seen_reg <= 1'b0;
			warn_reg      <= OUV_WARN_RST;
			fault_reg     <= OUV_FAULT_RST;
			act_reg       <= OUV_ACT_RST;
			rack_tgl_reg  <= 1'b0;
			rrsp_d_reg    <= 16'h0000;
			rrsp_e_reg    <= 1'b0;
			on_sync_reg   <= 2'h0;
		end else begin
			rreq_sync_reg <= {rreq_sync_reg[0], lreq_tgl_reg};
			rreq_seen_reg <= rreq_seen_next;
			warn_reg      <= warn_next;
			fault_reg     <= fault_next;
			act_reg       <= act_next;
			rack_tgl_reg  <= rack_tgl_next;
			rrsp_d_reg    <= rrsp_d_next;
			rrsp_e_reg    <= rrsp_e_next;
			on_sync_reg   <= {on_sync_reg[0], ctrl_on_pin};
		end
	end

	// ========================================
	// detection and restart sequencing
	ouv_state_t                state_reg, state_next;
	logic [OUV_STEP_CNT_W-1:0] cyc_reg, cyc_next;   // cycles in a step
	logic [2:0]                steps_reg, steps_next; // whole steps
	logic [2:0]                left_reg, left_next;   // attempts left
	logic                      cont_reg, cont_next;   // retry forever
	logic                      warn_o_reg, fault_o_reg;
	logic                      en_reg, en_next;
	logic                      warn_now, fault_now, steps_done, tmr_clr;
	// unsigned compare of the same-scaled codes
	function automatic logic below(input logic [15:0] v,
		input logic [15:0] thr);
		below = v < thr;
	endfunction

	assign warn_now   = below(vout_code, warn_reg);
	assign fault_now  = below(vout_code, fault_reg);
	assign steps_done = steps_reg >= act_reg.delay;

	// sequencer next state
	always_comb begin
		state_next = state_reg;
		left_next  = left_reg;
		cont_next  = cont_reg;
		tmr_clr    = 1'b0;
		case (state_reg)
			OUV_RUN: begin
				if (!on_now || other_fault)
					state_next = OUV_OFF;
				else if (fault_now &&
					act_reg.resp == OUV_RESP_SHUT) begin
					tmr_clr   = 1'b1;
					left_next = act_reg.retries;
					cont_next = act_reg.retries == OUV_RETRY_CONT;
					// no attempt budget: straight to latch
					state_next = (act_reg.retries == OUV_RETRY_NONE)
						? OUV_LATCH : OUV_HOLD;
				end
				// any other response rides through
			end
			OUV_OFF: begin
				if (on_now && !other_fault)
					state_next = OUV_RUN;
			end
			OUV_HOLD: begin
				if (!on_now || other_fault)
					state_next = OUV_OFF;
				else if (steps_done) begin
					// spacing restarts at each attempt start
					tmr_clr    = 1'b1;
					state_next = OUV_TRY;
					if (!cont_reg)
						left_next = left_reg - OUV_ONE3;
				end
			end
			OUV_TRY: begin
				if (!on_now || other_fault)
					state_next = OUV_OFF;
				else if (fault_now)
					// timer keeps running: start to start
					state_next = (left_reg == OUV_RETRY_NONE
						&& !cont_reg) ? OUV_LATCH : OUV_HOLD;
				else if (steps_done)
					state_next = OUV_RUN; // attempt held up
			end
			OUV_LATCH: begin
				if (fault_clear)
					state_next = OUV_OFF;
			end
			default: state_next = OUV_OFF;
		endcase
		en_next = state_next == OUV_RUN || state_next == OUV_TRY;
	end
	// step timer: whole 200 ms steps since the last clear
	always_comb begin
		cyc_next   = cyc_reg + OUV_STEP_CNT_W'(1);
		steps_next = steps_reg;
		if (tmr_clr) begin
			cyc_next   = '0;
			steps_next = 3'h0;
		end else if (cyc_reg == STEP_LAST) begin
			cyc_next = '0;
			if (steps_reg != OUV_STEPS_MAX)
				steps_next = steps_reg + OUV_ONE3;
		end
	end
	// sequencer registers
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg   <= OUV_OFF;
			cyc_reg     <= '0;
			steps_reg   <= 3'h0;
			left_reg    <= 3'h0;
			cont_reg    <= 1'b0;
			en_reg      <= 1'b0;
			warn_o_reg  <= 1'b0;
			fault_o_reg <= 1'b0;
		end else begin
			state_reg   <= state_next;
			cyc_reg     <= cyc_next;
			steps_reg   <= steps_next;
			left_reg    <= left_next;
			cont_reg    <= cont_next;
			en_reg      <= en_next;
			warn_o_reg  <= warn_now;
			fault_o_reg <= fault_now;
		end
	end

	assign out_enable = en_reg;
	assign uv_warn    = warn_o_reg;
	assign uv_fault   = fault_o_reg;
	assign retry_busy = state_reg == OUV_HOLD || state_reg == OUV_TRY;

	// ========================================
	// checks
	sequence run_fault_s;
		state_reg == OUV_RUN && on_now && !other_fault && fault_now;
	endsequence
	sequence try_fail_s;
		state_reg == OUV_TRY && on_now && !other_fault && fault_now;
	endsequence

	warn_flag_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		below(vout_code, warn_reg) |=> uv_warn)
		else $error("warning flag missed");
	fault_flag_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		uv_fault == $past(below(vout_code, fault_reg)))
		else $error("fault flag wrong");
	ignore_fault_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		run_fault_s ##0 act_reg.resp != OUV_RESP_SHUT |=> out_enable)
		else $error("ignored fault stopped output");
	shut_down_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		run_fault_s ##0 act_reg.resp == OUV_RESP_SHUT
		|=> !out_enable ##1 !out_enable)
		else $error("fault did not disable output");
	no_retry_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		state_reg == OUV_LATCH && !fault_clear |=> state_reg == OUV_LATCH)
		else $error("latched off left without clear");
	retry_budget_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		try_fail_s ##0 !cont_reg ##0 left_reg == OUV_RETRY_NONE
		|=> state_reg == OUV_LATCH)
		else $error("retries exceeded");
	attempt_space_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		state_reg == OUV_HOLD ##1 state_reg == OUV_TRY
		|-> $past(steps_reg) >= act_reg.delay && steps_reg == 3'h0)
		else $error("attempt started early");
	retry_forever_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		try_fail_s ##0 cont_reg |=> state_reg == OUV_HOLD)
		else $error("continuous retry stopped");
	cmd_off_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		!on_now |=> !out_enable)
		else $error("output on while commanded off");
endmodule

//--- inc/ouv_pkg.sv
// constants and types of the output under-voltage supervisor
package ouv_pkg;
	// ========================================
	// command codes of the three settings
	localparam logic [7:0]  OUV_CMD_WARN   = 8'h43; // warning threshold
	localparam logic [7:0]  OUV_CMD_FAULT  = 8'h44; // fault threshold
	localparam logic [7:0]  OUV_CMD_ACT    = 8'h45; // fault action
	// ========================================
	// reset values of the settings
	localparam logic [15:0] OUV_WARN_RST   = 16'h0000;
	localparam logic [15:0] OUV_FAULT_RST  = 16'h0000;
	localparam logic [7:0]  OUV_ACT_RST    = 8'h00;
	localparam logic [15:0] OUV_RD_NONE    = 16'h0000; // unmapped read
	// ========================================
	// field codes of the fault action
	localparam logic [1:0]  OUV_RESP_SHUT  = 2'h2;  // disable and retry
	localparam logic [2:0]  OUV_RETRY_NONE = 3'h0;  // no restart at all
	localparam logic [2:0]  OUV_RETRY_CONT = 3'h7;  // restart forever
	localparam logic [2:0]  OUV_STEPS_MAX  = 3'h7;  // step counter ceiling
	localparam logic [2:0]  OUV_ONE3       = 3'h1;
	// thresholds: volts = code * 2**OUV_VOUT_EXP
	localparam int          OUV_VOUT_EXP   = -5;
	// ========================================
	// timing
	localparam int unsigned OUV_REF_CLK_HZ = 10000000;
	localparam int unsigned OUV_STEP_MS    = 200;
	localparam int unsigned OUV_STEP_CYCLES =
		OUV_STEP_MS * (OUV_REF_CLK_HZ / 1000);
	localparam int          OUV_STEP_CNT_W = 21;
	// ========================================
	// types
	typedef struct packed {
		logic [1:0] resp;    // response to a fault
		logic [2:0] retries; // restart attempts
		logic [2:0] delay;   // steps between attempt starts
	} ouv_action_t;
	typedef struct packed {
		logic        write;  // 1 write, 0 read
		logic [7:0]  code;   // command code
		logic [15:0] data;   // write data
	} ouv_req_t;
	typedef enum logic [4:0] {
		OUV_RUN   = 5'h01, // converting
		OUV_OFF   = 5'h02, // commanded off or other fault
		OUV_HOLD  = 5'h04, // shut down, waiting for next attempt
		OUV_TRY   = 5'h08, // restart attempt in progress
		OUV_LATCH = 5'h10  // off until the fault is cleared
	} ouv_state_t;
endpackage

//--- dv/ouv_host.sv
// host model that drives the decoded management link
`timescale 1ns/1ps
module ouv_host
	import ouv_pkg::*;
(
	input  wire logic link_clk,
	output ouv_req_t  pm_req,
	output logic      pm_req_valid,
	input  wire logic pm_req_ready,
	input  wire logic pm_rsp_valid
);
	// ========================================
	// idle at time zero
	initial begin
		pm_req = '0;
		pm_req_valid = 1'b0;
	end
	// ========================================
	// one whole request; held until a rising edge takes it
	task automatic xfer(input logic w, input logic [7:0] c,
		input logic [15:0] d);
		int n;
		n = 0;
		@(negedge link_clk);
		pm_req = {w, c, d};
		pm_req_valid = 1'b1;
		// ready is stable here, so the next rise takes it
		while (pm_req_ready !== 1'b1 && n < 20) begin
			@(negedge link_clk);
			n++;
		end
		@(negedge link_clk);
		pm_req_valid = 1'b0;
		// released lines must not keep the old value
		pm_req = ~pm_req;
		n = 0;
		// one outstanding request: wait for its answer
		while (pm_rsp_valid !== 1'b1 && n < 20) begin
			@(negedge link_clk);
			n++;
		end
	endtask
endmodule

//--- dv/testbench.sv
// self-checking bench of the under-voltage supervisor
`timescale 1ns/1ps
module testbench;
	import ouv_pkg::*;
	localparam int unsigned SC = 4; // short step for simulation
	logic        ref_clk, link_clk, resetn;
	ouv_req_t    pm_req;
	logic        pm_req_valid, pm_req_ready, pm_rsp_valid, pm_rsp_err;
	logic [15:0] pm_rsp_data, vout_code;
	logic        ctrl_on_pin, other_fault, fault_clear;
	logic        out_enable, uv_warn, uv_fault, retry_busy;
	int          bad_count, comparisons, seed, rises, gap, last_r, cyc_n;
	logic [16:0] exp_q [$];  // expected {err, data} of answers
	logic [15:0] shadow [3]; // expected register contents
	logic        en_d;
	logic [2:0]  d;
	// ========================================
	// clocks, unrelated in phase
	initial ref_clk = 1'b0;
	always #50 ref_clk = ~ref_clk;
	initial begin
		link_clk = 1'b0;
		#37;
		forever #80 link_clk = ~link_clk;
	end
	ouv_supervisor #(.STEP_CYCLES(SC)) ouv_supervisor_i (.ref_clk(ref_clk),
		.resetn(resetn), .link_clk(link_clk), .pm_req(pm_req),
		.pm_req_valid(pm_req_valid), .pm_req_ready(pm_req_ready),
		.pm_rsp_valid(pm_rsp_valid), .pm_rsp_data(pm_rsp_data),
		.pm_rsp_err(pm_rsp_err), .vout_code(vout_code),
		.ctrl_on_pin(ctrl_on_pin), .other_fault(other_fault),
		.fault_clear(fault_clear), .out_enable(out_enable),
		.uv_warn(uv_warn), .uv_fault(uv_fault), .retry_busy(retry_busy));
	ouv_host ouv_host_i (.link_clk(link_clk), .pm_req(pm_req),
		.pm_req_valid(pm_req_valid), .pm_req_ready(pm_req_ready),
		.pm_rsp_valid(pm_rsp_valid));
	// ========================================
	// comparison and verdict
	task automatic check(input logic [16:0] seen, input logic [16:0] want);
		comparisons++;
		if (seen !== want) begin
			bad_count++;
			$display("wrong value at %0t: seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic results();
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	// register access; the answer is noted before the request goes out
	task automatic reg_op(input logic w, input logic [7:0] c,
		input logic [15:0] v);
		logic [16:0] e;
		int k;
		k = int'(c) - int'(OUV_CMD_WARN);
		e = {1'b1, OUV_RD_NONE};
		if (k >= 0 && k <= 2) begin
			e = {1'b0, shadow[k]};
			if (w) shadow[k] = (k == 2) ? {8'h00, v[7:0]} : v;
		end
		exp_q.push_back(e);
		ouv_host_i.xfer(w, c, v);
	endtask
	// leave the latched state and expect the output back on
	task automatic recover();
		vout_code = 16'hFFFF;
		cyc(2);
		fault_clear = 1'b1;
		cyc(1);
		fault_clear = 1'b0;
		cyc(5);
		check(out_enable, 1'b1);
	endtask
	// ========================================
	// answer watcher: oldest note against each answer pulse
	always @(negedge link_clk) begin
		if (pm_rsp_valid === 1'b1) begin
			if (exp_q.size() == 0) check(17'h1, 17'h0);
			else check({pm_rsp_err, pm_rsp_data}, exp_q.pop_front());
		end
	end
	// restart attempts show as rises of the output enable
	always @(negedge ref_clk) begin
		cyc_n++;
		if (out_enable === 1'b1 && en_d !== 1'b1) begin
			rises++;
			gap = cyc_n - last_r;
			last_r = cyc_n;
		end
		en_d = out_enable;
	end
	// watchdog: the whole sequence needs well under 2 ms
	initial begin
		#2000000;
		bad_count++;
		results();
	end
	// ========================================
	// main sequence
	initial begin
		seed = 32'h2aef97f1;
		resetn = 1'b0;
		vout_code = 16'hFFFF;
		ctrl_on_pin = 1'b1;
		other_fault = 1'b0;
		fault_clear = 1'b0;
		shadow = '{OUV_WARN_RST, OUV_FAULT_RST, {8'h00, OUV_ACT_RST}};
		cyc(10);
		resetn = 1'b1;
		cyc(6);
		check(out_enable, 1'b1);
		// random settings, read back, unmapped code, then real limits
		for (int c = 8'h43; c <= 8'h46; c++) begin
			reg_op(1'b1, 8'(c), 16'($random(seed)));
			reg_op(1'b0, 8'(c), 16'h0000);
		end
		reg_op(1'b1, OUV_CMD_WARN, 16'h0200);
		reg_op(1'b1, OUV_CMD_FAULT, 16'h0100);
		reg_op(1'b1, OUV_CMD_ACT, 16'h0000);
		// warning only, then both limits at their exact boundary
		vout_code = 16'h01FF;
		cyc(3);
		check({uv_warn, uv_fault, out_enable}, 3'b101);
		vout_code = 16'h0200;
		cyc(3);
		check(uv_warn, 1'b0);
		vout_code = 16'h0100;
		cyc(3);
		check(uv_fault, 1'b0);
		// responses other than shutdown keep converting
		for (int r = 0; r < 4; r++) begin
			if (r == 2) continue;
			reg_op(1'b1, OUV_CMD_ACT, {8'h00, 2'(r), 3'h1, 3'h1});
			vout_code = 16'h00FF;
			cyc(8 * SC);
			check({uv_fault, out_enable, retry_busy}, 3'b110);
			vout_code = 16'hFFFF;
		end
		// no retry: off until cleared even once the voltage recovers
		reg_op(1'b1, OUV_CMD_ACT, {8'h00, OUV_RESP_SHUT, OUV_RETRY_NONE, 3'h1});
		rises = 0;
		vout_code = 16'h0010;
		cyc(16 * SC);
		vout_code = 16'hFFFF;
		cyc(5);
		check({rises != 0, out_enable, retry_busy}, 3'b000);
		recover();
		// one to six attempts, spaced start to start by the delay
		for (int n = 1; n <= 6; n++) begin
			d = 3'({$random(seed)} % 3 + 1);
			reg_op(1'b1, OUV_CMD_ACT, {8'h00, OUV_RESP_SHUT, 3'(n), d});
			rises = 0;
			vout_code = 16'h0010;
			cyc(2);
			check({out_enable, retry_busy}, 2'b01);
			cyc(7 * 8 * SC);
			check(17'(rises), 17'(n));
			check({out_enable, retry_busy}, 2'b00);
			if (n > 1) check(gap >= d * SC && gap <= d * SC + 1, 1'b1);
			recover();
		end
		// a restart that meets no fault brings the output back for good
		reg_op(1'b1, OUV_CMD_ACT, {8'h00, OUV_RESP_SHUT, 3'h3, 3'h1});
		rises = 0;
		vout_code = 16'h0010;
		cyc(2);
		vout_code = 16'hFFFF;
		cyc(4 * SC);
		check({rises == 1, out_enable, retry_busy}, 3'b110);
		// endless retries stop on the control pin; another fault stops the running output
		reg_op(1'b1, OUV_CMD_ACT, {8'h00, OUV_RESP_SHUT, OUV_RETRY_CONT, 3'h1});
		rises = 0;
		vout_code = 16'h0010;
		cyc(25 * SC);
		check(rises > 15, 1'b1);
		ctrl_on_pin = 1'b0;
		cyc(5);
		rises = 0;
		cyc(10 * SC);
		check({rises != 0, out_enable, retry_busy}, 3'b000);
		vout_code = 16'hFFFF;
		ctrl_on_pin = 1'b1;
		cyc(6);
		check(out_enable, 1'b1);
		other_fault = 1'b1;
		cyc(3);
		check(out_enable, 1'b0);
		other_fault = 1'b0;
		cyc(40);
		// every noted answer must have arrived
		check(17'(exp_q.size()), 17'h0);
		results();
	end
endmodule
